/* File: src/eipd_detector.sv */
`timescale 1ns/1ps
`include "eipd_map.svh"

// Functional notes
// - With pin enabled, pullup on when pull-disable bit 6 is zero, off when one.
// - Pin acts as interrupt input only while enable bit 4 is set.
// - Read-only bit 3 shows the latched event flag.
// - Writing one to bit 2 clears the flag; writing zero does nothing.
// - Bit 2 always reads zero.
// - In edge-and-level mode the flag cannot clear while the pin stays low.
// - With bit 1 set, the CPU request follows the flag; otherwise polling only.
// - Bit 0 clear: falling edges only; set: falling edges and low levels.
module eipd_detector (
    // Clock and reset.
    input  wire logic                     clock,
    input  wire logic                     reset,
    // Register port.
    input  wire logic [`EIPD_ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [7:0]                    reg_rdata,
    // Interrupt pin.
    input  wire logic                     irq_pin,
    output logic                          pullup_en,
    // Requests to the CPU.
    output logic                          cpu_irq,
    output logic                          event_irq
);

    eipd_pkg::eipd_ctrl_t ctrl_q;
    eipd_pkg::eipd_det_t  det;
    logic                 flag_q;
    logic                 ack_wr;
    logic                 set_evt;
    logic                 clear_ok;
    logic [7:0]           rdata_d;
    logic [7:0]           rdata_q;
    logic [`EIPD_INT_W-1:0] int_status;
    logic [`EIPD_INT_W-1:0] int_mask;
    logic [`EIPD_INT_W-1:0] int_events;

    // Address decode used by write and read paths.
    function automatic logic hit(input logic [`EIPD_ADDR_W-1:0] a, input logic [`EIPD_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Pin front end.
    eipd_pin_sync u_sync (
        .clock  (clock),
        .reset  (reset),
        .pin_in (irq_pin),
        .det    (det)
    );

    // Control bits; bit 5 is dropped since software keeps it zero.
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_q <= '0;
        end else if (reg_wr && hit(reg_addr, `EIPD_OFS_CTRL)) begin
            ctrl_q.pull_disable     <= reg_wdata[`EIPD_BIT_PULL_DIS];
            ctrl_q.function_enable  <= reg_wdata[`EIPD_BIT_PIN_EN];
            ctrl_q.interrupt_enable <= reg_wdata[`EIPD_BIT_IRQ_EN];
            ctrl_q.detect_mode      <= reg_wdata[`EIPD_BIT_MODE];
        end
    end

    // Acknowledge is a one-bit write strobe; a zero in that bit changes nothing.
    assign ack_wr = reg_wr && hit(reg_addr, `EIPD_OFS_CTRL) && reg_wdata[`EIPD_BIT_ACK];

    // Events count only while the pin function is on; level counts in mode one.
    assign set_evt = ctrl_q.function_enable
                   & (det.fall | (ctrl_q.detect_mode & det.low));

    // A held low level blocks the acknowledge in edge-and-level mode.
    assign clear_ok = ack_wr & ~(ctrl_q.detect_mode & det.low & ctrl_q.function_enable);

    // Flag: a detection in the same cycle as an acknowledge wins.
    always_ff @(posedge clock) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (set_evt) begin
            flag_q <= 1'b1;
        end else if (clear_ok) begin
            flag_q <= 1'b0;
        end
    end

    // Pullup only matters with the pin function enabled.
    assign pullup_en = ctrl_q.function_enable & ~ctrl_q.pull_disable;

    // CPU request follows the flag while enabled.
    assign cpu_irq = ctrl_q.interrupt_enable & flag_q;

    // Sticky event log for the mask-gated summary line.
    assign int_events = {set_evt & ctrl_q.detect_mode & det.low, set_evt & det.fall};

    eipd_int_ctrl u_int (
        .clock    (clock),
        .reset    (reset),
        .event_in (int_events),
        .stat_wr  (reg_wr && hit(reg_addr, `EIPD_OFS_INT_STATUS)),
        .mask_wr  (reg_wr && hit(reg_addr, `EIPD_OFS_INT_MASK)),
        .wdata    (reg_wdata[`EIPD_INT_W-1:0]),
        .status_q (int_status),
        .mask_q   (int_mask),
        .irq      (event_irq)
    );

    // Read mux; acknowledge and reserved bits read zero, unmapped reads zero.
    always_comb begin
        rdata_d = 8'h00;
        if (hit(reg_addr, `EIPD_OFS_CTRL)) begin
            rdata_d[`EIPD_BIT_PULL_DIS] = ctrl_q.pull_disable;
            rdata_d[`EIPD_BIT_PIN_EN]   = ctrl_q.function_enable;
            rdata_d[`EIPD_BIT_FLAG]     = flag_q;
            rdata_d[`EIPD_BIT_ACK]      = 1'b0;
            rdata_d[`EIPD_BIT_IRQ_EN]   = ctrl_q.interrupt_enable;
            rdata_d[`EIPD_BIT_MODE]     = ctrl_q.detect_mode;
        end else if (hit(reg_addr, `EIPD_OFS_INT_STATUS)) begin
            rdata_d[`EIPD_INT_W-1:0] = int_status;
        end else if (hit(reg_addr, `EIPD_OFS_INT_MASK)) begin
            rdata_d[`EIPD_INT_W-1:0] = int_mask;
        end
    end

    // Read data registered so it stands the cycle after the strobe only.
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rdata_d : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;

    // Assertions.
    pull_follows_bits_a: assert property (@(posedge clock) disable iff (reset)
        pullup_en == (ctrl_q.function_enable && !ctrl_q.pull_disable))
        else $error("pullup enable mismatch");

    disabled_no_set_a: assert property (@(posedge clock) disable iff (reset)
        (!ctrl_q.function_enable && !flag_q) |=> !flag_q)
        else $error("flag set while pin function disabled");

    flag_read_back_a: assert property (@(posedge clock) disable iff (reset)
        (reg_rd && reg_addr == `EIPD_OFS_CTRL) |=> reg_rdata[`EIPD_BIT_FLAG] == $past(flag_q))
        else $error("flag read mismatch");

    ack_clears_flag_a: assert property (@(posedge clock) disable iff (reset)
        (ack_wr && !set_evt && !(ctrl_q.detect_mode && det.low)) |=> !flag_q)
        else $error("acknowledge did not clear flag");

    ack_zero_keeps_a: assert property (@(posedge clock) disable iff (reset)
        (flag_q && !ack_wr) |=> flag_q)
        else $error("flag cleared without acknowledge");

    ack_reads_zero_a: assert property (@(posedge clock) disable iff (reset)
        ##1 !reg_rdata[`EIPD_BIT_ACK])
        else $error("acknowledge bit read nonzero");

    level_holds_flag_a: assert property (@(posedge clock) disable iff (reset)
        (ctrl_q.function_enable && ctrl_q.detect_mode && det.low) |=> flag_q)
        else $error("flag clear while pin low in level mode");

    cpu_req_tracks_a: assert property (@(posedge clock) disable iff (reset)
        cpu_irq == (flag_q && ctrl_q.interrupt_enable))
        else $error("cpu request mismatch");

    edge_sets_flag_a: assert property (@(posedge clock) disable iff (reset)
        (ctrl_q.function_enable && det.fall) |=> flag_q)
        else $error("falling edge missed");

    edge_mode_level_a: assert property (@(posedge clock) disable iff (reset)
        (!flag_q && !ctrl_q.detect_mode && !det.fall) |=> !flag_q)
        else $error("flag set without edge in edge mode");

    sync_delay_a: assert property (@(posedge clock) disable iff (reset)
        ($fell(irq_pin) ##1 !irq_pin ##1 !irq_pin) |-> det.fall || $past(det.fall) || !$past(det.low,3))
        else $error("falling edge not seen after sync");

    // A disabled pin function must never leave the pullup switched on.
    pullup_off_disabled_a: assert property (@(posedge clock) disable iff (reset)
        !ctrl_q.function_enable |-> !pullup_en)
        else $error("pullup on while pin function disabled");

    // A held low level keeps the flag through any acknowledge in edge-and-level mode.
    ack_blocked_low_a: assert property (@(posedge clock) disable iff (reset)
        (flag_q && ctrl_q.function_enable && ctrl_q.detect_mode && det.low && ack_wr) |=> flag_q)
        else $error("acknowledge cleared flag while pin low");

    // With the interrupt enable clear, software must poll, so no request is raised.
    req_off_polled_a: assert property (@(posedge clock) disable iff (reset)
        !ctrl_q.interrupt_enable |-> !cpu_irq)
        else $error("cpu request while interrupt disabled");

    // Read data stand only in the cycle after a read strobe and are zero otherwise.
    rdata_idle_zero_a: assert property (@(posedge clock) disable iff (reset)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without read strobe");

endmodule : eipd_detector

/* File: include/eipd_map.svh */
`ifndef EIPD_MAP_SVH
`define EIPD_MAP_SVH

// Register addresses on the plain register port.
`define EIPD_ADDR_W          4
`define EIPD_OFS_CTRL        4'h0
`define EIPD_OFS_INT_STATUS  4'h1
`define EIPD_OFS_INT_MASK    4'h2

// Field positions of the status and control register.
`define EIPD_BIT_PULL_DIS    6
`define EIPD_BIT_RSVD        5
`define EIPD_BIT_PIN_EN      4
`define EIPD_BIT_FLAG        3
`define EIPD_BIT_ACK         2
`define EIPD_BIT_IRQ_EN      1
`define EIPD_BIT_MODE        0

// Reset values.
`define EIPD_CTRL_RESET      8'h00
`define EIPD_INT_RESET       8'h00

// Interrupt status bits.
`define EIPD_INT_BIT_EDGE    0
`define EIPD_INT_BIT_LEVEL   1
`define EIPD_INT_W           2

// Synchroniser depth.
`define EIPD_SYNC_STAGES     2

`endif

/* File: include/eipd_pkg.sv */
package eipd_pkg;

    // Decoded control fields of the status and control register.
    typedef struct packed {
        logic pull_disable;
        logic function_enable;
        logic interrupt_enable;
        logic detect_mode;
    } eipd_ctrl_t;

    // Register port request as one bundle.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } eipd_req_t;

    // Detection results from the pin front end.
    typedef struct packed {
        logic fall;
        logic low;
    } eipd_det_t;

endpackage : eipd_pkg

/* File: src/eipd_pin_sync.sv */
`timescale 1ns/1ps
`include "eipd_map.svh"

module eipd_pin_sync (
    // Clock and reset.
    input  wire logic               clock,
    input  wire logic               reset,
    // Raw pin level and results.
    input  wire logic               pin_in,
    output eipd_pkg::eipd_det_t     det
);

    logic [`EIPD_SYNC_STAGES-1:0] sync_q;
    logic                         prev_q;

    // Two flops; only the last stage is looked at, and the idle level is high.
    always_ff @(posedge clock) begin
        if (reset) begin
            sync_q <= '1;
        end else begin
            sync_q <= {sync_q[`EIPD_SYNC_STAGES-2:0], pin_in};
        end
    end

    // Previous synchronised value for falling-edge compare.
    always_ff @(posedge clock) begin
        if (reset) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= sync_q[`EIPD_SYNC_STAGES-1];
        end
    end

    // Edge is old high, new low; level is plain low.
    assign det.fall = prev_q & ~sync_q[`EIPD_SYNC_STAGES-1];
    assign det.low  = ~sync_q[`EIPD_SYNC_STAGES-1];

endmodule : eipd_pin_sync

/* File: src/eipd_int_ctrl.sv */
`timescale 1ns/1ps
`include "eipd_map.svh"

module eipd_int_ctrl (
    // Clock and reset.
    input  wire logic                    clock,
    input  wire logic                    reset,
    // Events and software access.
    input  wire logic [`EIPD_INT_W-1:0]  event_in,
    input  wire logic                    stat_wr,
    input  wire logic                    mask_wr,
    input  wire logic [`EIPD_INT_W-1:0]  wdata,
    // State and line.
    output logic [`EIPD_INT_W-1:0]       status_q,
    output logic [`EIPD_INT_W-1:0]       mask_q,
    output logic                         irq
);

    // Sticky bits; write one clears, but a new event wins over the clear.
    always_ff @(posedge clock) begin
        if (reset) begin
            status_q <= `EIPD_INT_W'(`EIPD_INT_RESET);
        end else begin
            status_q <= (status_q & ~(stat_wr ? wdata : '0)) | event_in;
        end
    end

    // Mask register.
    always_ff @(posedge clock) begin
        if (reset) begin
            mask_q <= `EIPD_INT_W'(`EIPD_INT_RESET);
        end else if (mask_wr) begin
            mask_q <= wdata;
        end
    end

    // Level output while any enabled bit is set.
    assign irq = |(status_q & mask_q);

endmodule : eipd_int_ctrl

/* File: verification/eipd_pin_model.sv */
`timescale 1ns/1ps

// External device on the request pin: it drives the line when told, else leaves it to the pull.
module eipd_pin_model (
    // Clock.
    input  wire logic clock,
    // Commands from the bench.
    input  wire logic drive_en,
    input  wire logic drive_low,
    // Pin side.
    input  wire logic pullup_en,
    output logic      irq_pin
);
    logic float_q = 1'b0;

    // A released pin with no pullup has no defined level, so it wanders every cycle.
    always @(posedge clock) begin
        float_q <= ~float_q;
    end

    // A driven level wins; otherwise the pullup holds the line high.
    always_comb begin
        if (drive_en) begin
            irq_pin = ~drive_low;
        end else if (pullup_en) begin
            irq_pin = 1'b1;
        end else begin
            irq_pin = float_q;
        end
    end
endmodule : eipd_pin_model

/* File: verification/tb_external_irq_pin_detector.sv */
`timescale 1ns/1ps
`include "eipd_map.svh"

module tb_external_irq_pin_detector;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        drive_en = 1'b1;
    logic        drive_low = 1'b0;
    logic [7:0]  reg_rdata, d;
    logic        irq_pin, pullup_en, cpu_irq, event_irq;
    logic [31:0] rnd = 32'd17;
    int          fails = 0, compares = 0, cycles = 0, i;

    eipd_detector eipd_detector_i (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pin(irq_pin), .pullup_en(pullup_en),
        .cpu_irq(cpu_irq), .event_irq(event_irq));
    eipd_pin_model eipd_pin_model_i (.clock(clock), .drive_en(drive_en), .drive_low(drive_low),
        .pullup_en(pullup_en), .irq_pin(irq_pin));

    // Free-running 40 MHz clock.
    always #12.5 clock = ~clock;

    // A hung sequence is cut short well above the fewer than two hundred cycles the tests need.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            give_verdict();
        end
    end

    function automatic logic [31:0] next_rnd(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : next_rnd

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    // One write cycle; it takes effect at the edge that ends the task.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // One read cycle; the data stand only in the following cycle.
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata & m);
    endtask : rd_chk

    // Sets the pin level and holds it for n cycles.
    task automatic pin(input logic low, input int n);
        @(posedge clock);
        drive_low <= low;
        repeat (n) @(posedge clock);
    endtask : pin

    task automatic give_verdict();
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // Main sequence.
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        rd_chk("ctrl at reset", `EIPD_OFS_CTRL, `EIPD_CTRL_RESET, 8'hff);
        rd_chk("status at reset", `EIPD_OFS_INT_STATUS, `EIPD_INT_RESET, 8'hff);
        rd_chk("mask at reset", `EIPD_OFS_INT_MASK, `EIPD_INT_RESET, 8'hff);
        chk("pullup at reset", 8'h00, {7'h0, pullup_en});
        // Random control words with the pin held high; the flag and ack bits must read zero.
        for (i = 0; i < 12; i++) begin
            rnd = next_rnd(rnd);
            d = rnd[7:0] & 8'hdf;
            wr(`EIPD_OFS_CTRL, d);
            rd_chk("ctrl readback", `EIPD_OFS_CTRL, d & 8'h53, 8'hff);
            chk("pullup", {7'h0, d[4] & ~d[6]}, {7'h0, pullup_en});
        end
        rd_chk("unmapped read", 4'hf, 8'h00, 8'hff);
        wr(4'h7, 8'h13);
        rd_chk("ctrl after unmapped write", `EIPD_OFS_CTRL, d & 8'h53, 8'hff);
        // Edge mode, polled first, with a random low width.
        wr(`EIPD_OFS_CTRL, 8'h10);
        wr(`EIPD_OFS_INT_STATUS, 8'h03);
        rnd = next_rnd(rnd);
        pin(1'b1, 2 + rnd[1:0]);
        pin(1'b0, 6);
        rd_chk("flag after edge", `EIPD_OFS_CTRL, 8'h18, 8'hff);
        chk("request while polled", 8'h00, {7'h0, cpu_irq});
        wr(`EIPD_OFS_CTRL, 8'h12);
        chk("request enabled", 8'h01, {7'h0, cpu_irq});
        rd_chk("flag after zero ack", `EIPD_OFS_CTRL, 8'h1a, 8'hff);
        // A held low level is no event in edge mode, so an ack clears for good.
        pin(1'b1, 6);
        wr(`EIPD_OFS_CTRL, 8'h16);
        repeat (6) @(posedge clock);
        rd_chk("flag after ack", `EIPD_OFS_CTRL, 8'h12, 8'hff);
        chk("request after ack", 8'h00, {7'h0, cpu_irq});
        pin(1'b0, 4);
        // Sticky status, mask and the level interrupt line.
        rd_chk("edge status", `EIPD_OFS_INT_STATUS, 8'h01, 8'hff);
        chk("masked line", 8'h00, {7'h0, event_irq});
        wr(`EIPD_OFS_INT_MASK, 8'h01);
        chk("unmasked line", 8'h01, {7'h0, event_irq});
        wr(`EIPD_OFS_INT_STATUS, 8'h01);
        chk("line after clear", 8'h00, {7'h0, event_irq});
        rd_chk("status after clear", `EIPD_OFS_INT_STATUS, 8'h00, 8'hff);
        // Edge-and-level mode: an ack cannot clear while the pin stays low.
        wr(`EIPD_OFS_CTRL, 8'h13);
        pin(1'b1, 6);
        wr(`EIPD_OFS_CTRL, 8'h17);
        rd_chk("flag held low", `EIPD_OFS_CTRL, 8'h1b, 8'hff);
        chk("request held low", 8'h01, {7'h0, cpu_irq});
        rd_chk("level status", `EIPD_OFS_INT_STATUS, 8'h02, 8'h02);
        pin(1'b0, 6);
        wr(`EIPD_OFS_CTRL, 8'h17);
        rd_chk("flag after release", `EIPD_OFS_CTRL, 8'h13, 8'hff);
        // Pin function off: a floating line and a driven pulse raise nothing.
        wr(`EIPD_OFS_CTRL, 8'h03);
        @(posedge clock);
        drive_en <= 1'b0;
        repeat (20) @(posedge clock);
        drive_en <= 1'b1;
        pin(1'b1, 6);
        pin(1'b0, 4);
        rd_chk("flag with pin off", `EIPD_OFS_CTRL, 8'h03, 8'hff);
        chk("pullup with pin off", 8'h00, {7'h0, pullup_en});
        give_verdict();
    end
endmodule : tb_external_irq_pin_detector
